// ===== hdl/hdi_master.sv
`timescale 1ns/1ps
`include "hdi_defs.svh"
module hdi_master
  import hdi_pkg::*;
#(
  parameter int QTR_CYC = `HDI_QTR_CYC
)(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      reset,
  // serial bus
  hdi_if.master          bus,
  // request
  input  wire logic      reqValid,
  input  wire logic      reqWrite,
  input  wire hdi_byte_t reqReg,
  input  wire hdi_byte_t reqData,
  output logic           reqReady,
  // response
  output logic           rspValid,
  output hdi_byte_t      rspData,
  output logic           rspNack
);

  localparam int QW = $clog2(QTR_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers and quarter-bit divider

  logic [1:0]    sclSync_q;
  logic [1:0]    sdaSync_q;
  logic [QW-1:0] qCnt_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
    end else begin
      sclSync_q <= {sclSync_q[0], bus.scl};
      sdaSync_q <= {sdaSync_q[0], bus.sda};
    end
  end

  hdi_mst_t   state_q;
  logic [1:0] ph_q;
  logic [2:0] bitCnt_q;
  logic [1:0] byteNo_q;
  hdi_byte_t  shift_q;
  logic       write_q;
  hdi_byte_t  data_q;
  hdi_byte_t  reg_q;
  logic       nack_q;
  logic       sclOe_q;
  logic       sdaOe_q;

  wire logic sclNow  = sclSync_q[1];
  wire logic sdaNow  = sdaSync_q[1];
  wire logic tick    = (qCnt_q == '0) && (state_q != M_IDLE);
  // waits for scl to read high, so a held-low clock only slows the bus
  wire logic step    = tick && !(ph_q == 2'h2 && !sclNow);
  wire logic slotEnd = step && (ph_q == 2'h3);
  wire logic accept  = (state_q == M_IDLE) && reqValid && reqReady;

  // four quarters of at least the 400 kbit/s bit time
  always_ff @(posedge clk) begin
    if (reset || accept || qCnt_q == '0) begin
      qCnt_q <= QW'(QTR_CYC - 1);
    end else begin
      qCnt_q <= qCnt_q - 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line drivers per quarter

  always_ff @(posedge clk) begin
    if (reset) begin
      sclOe_q <= 1'h0;
      sdaOe_q <= 1'h0;
    end else if (step) begin
      case (ph_q)
        2'h0: begin
          sdaOe_q <= (state_q == M_STOP) | ((state_q == M_TXB) & ~shift_q[7]);
        end
        2'h1: begin
          sclOe_q <= 1'h0;
        end
        2'h2: begin
          if (state_q == M_START) begin
            sdaOe_q <= 1'h1;
          end else if (state_q == M_STOP) begin
            sdaOe_q <= 1'h0;
          end
        end
        default: begin
          sclOe_q <= (state_q != M_STOP);
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= M_IDLE;
      ph_q     <= 2'h0;
      bitCnt_q <= 3'h0;
      byteNo_q <= 2'h0;
      shift_q  <= 8'h00;
      write_q  <= 1'h0;
      data_q   <= 8'h00;
      reg_q    <= 8'h00;
      nack_q   <= 1'h0;
      reqReady <= 1'h1;
      rspValid <= 1'h0;
      rspData  <= 8'h00;
      rspNack  <= 1'h0;
    end else begin
      rspValid <= 1'h0;
      if (accept) begin
        state_q  <= M_START;
        ph_q     <= 2'h0;
        byteNo_q <= 2'h0;
        nack_q   <= 1'h0;
        write_q  <= reqWrite;
        reg_q    <= reqReg;
        data_q   <= reqData;
        shift_q  <= {`HDI_SLAVE_ADDR, `HDI_WRITE_BIT};
        reqReady <= 1'h0;
      end else if (step) begin
        ph_q <= ph_q + 2'h1;
        if (ph_q == 2'h2 && state_q == M_ACKR) begin
          nack_q <= sdaNow;
        end
        if (ph_q == 2'h2 && state_q == M_RXB) begin
          shift_q <= {shift_q[6:0], sdaNow};
        end
      end
      if (slotEnd) begin
        case (state_q)
          M_START: begin
            state_q  <= M_TXB;
            bitCnt_q <= 3'h0;
          end
          M_TXB: begin
            bitCnt_q <= bitCnt_q + 3'h1;
            shift_q  <= {shift_q[6:0], 1'h0};
            if (bitCnt_q == 3'h7) begin
              state_q <= M_ACKR;
            end
          end
          M_ACKR: begin
            bitCnt_q <= 3'h0;
            if (nack_q) begin
              state_q <= M_STOP;
            end else if (byteNo_q == 2'h0) begin
              shift_q  <= reg_q;
              byteNo_q <= 2'h1;
              state_q  <= M_TXB;
            end else if (byteNo_q == 2'h1 && write_q) begin
              shift_q  <= data_q;
              byteNo_q <= 2'h2;
              state_q  <= M_TXB;
            end else if (byteNo_q == 2'h1) begin
              shift_q  <= {`HDI_SLAVE_ADDR, `HDI_READ_BIT};
              byteNo_q <= 2'h2;
              state_q  <= M_START;
            end else begin
              state_q <= write_q ? M_STOP : M_RXB;
            end
          end
          M_RXB: begin
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
              state_q <= M_NACK;
            end
          end
          M_NACK: begin
            state_q <= M_STOP;
          end
          M_STOP: begin
            state_q  <= M_IDLE;
            reqReady <= 1'h1;
            rspValid <= 1'h1;
            rspData  <= write_q ? 8'h00 : shift_q;
            rspNack  <= nack_q;
          end
          default: begin
            state_q <= M_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.mSclOut = 1'h0;
  assign bus.mSclOe  = sclOe_q;
  assign bus.mSdaOut = 1'h0;
  assign bus.mSdaOe  = sdaOe_q;

endmodule

// ===== hdl/hdi_slave.sv
`timescale 1ns/1ps
`include "hdi_defs.svh"
module hdi_slave
  import hdi_pkg::*;
#(
  parameter int NUM_REGS = `HDI_NUM_REGS
)(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      reset,
  // serial bus
  hdi_if.slave           bus,
  // device side
  input  wire logic      overTemp,
  output hdi_byte_t      cfgReg,
  output hdi_byte_t      oscReg,
  output hdi_byte_t      hapticAReg,
  output hdi_byte_t      hapticBReg,
  output hdi_byte_t      ldoHReg,
  output hdi_byte_t      ldoVReg
);

  localparam int IDXW = $clog2(NUM_REGS);

  function automatic hdi_byte_t regReset(input int idx);
    case (idx)
      0: regReset = `HDI_RST_CONFIG;
      1: regReset = `HDI_RST_OSC;
      2: regReset = `HDI_RST_HAPTIC_A;
      3: regReset = `HDI_RST_HAPTIC_B;
      4: regReset = `HDI_RST_LDO_H;
      5: regReset = `HDI_RST_LDO_V;
      default: regReset = 8'h00;
    endcase
  endfunction

  // reserved bits are never stored, so they read as zero
  function automatic hdi_byte_t regMask(input int idx);
    case (idx)
      0: regMask = `HDI_MSK_CONFIG;
      1: regMask = `HDI_MSK_OSC;
      2: regMask = `HDI_MSK_HAPTIC;
      3: regMask = `HDI_MSK_HAPTIC;
      4: regMask = `HDI_MSK_LDO;
      5: regMask = `HDI_MSK_LDO;
      default: regMask = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic [1:0]  sclSync_q;
  logic [1:0]  sdaSync_q;
  logic        sclDly_q;
  logic        sdaDly_q;

  // bit rate ceiling keeps a quarter bit far above the three-cycle sync delay
  always_ff @(posedge clk) begin
    if (reset) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclDly_q  <= 1'h1;
      sdaDly_q  <= 1'h1;
    end else begin
      sclSync_q <= {sclSync_q[0], bus.scl};
      sdaSync_q <= {sdaSync_q[0], bus.sda};
      sclDly_q  <= sclSync_q[1];
      sdaDly_q  <= sdaSync_q[1];
    end
  end

  wire logic sclNow    = sclSync_q[1];
  wire logic sdaNow    = sdaSync_q[1];
  wire logic sclRise   = sclNow & ~sclDly_q;
  wire logic sclFall   = ~sclNow & sclDly_q;
  wire logic startSeen = sclNow & sclDly_q & sdaDly_q & ~sdaNow;
  wire logic stopSeen  = sclNow & sclDly_q & ~sdaDly_q & sdaNow;

  ////////////////////////////////////////////////////////////////////////////////
  // protocol engine

  hdi_sst_t    state_q;
  logic [3:0]  cnt_q;
  logic [1:0]  byteIdx_q;
  hdi_byte_t   shift_q;
  hdi_byte_t   ptr_q;
  logic        rnw_q;
  logic        sdaOe_q;
  hdi_byte_t   regs_q [NUM_REGS];

  wire logic      rxFull   = (cnt_q == 4'h8);
  wire logic      byteDone = (state_q == S_RX) & sclFall & rxFull;
  wire logic      addrMiss = (shift_q[7:1] != `HDI_SLAVE_ADDR);
  wire logic      ptrValid = (ptr_q < 8'(NUM_REGS));
  wire logic      wrEn     = byteDone & (byteIdx_q == 2'h2);
  wire hdi_byte_t rdByte   = ptrValid ? regs_q[ptr_q[IDXW-1:0]] : 8'h00;

  // slave never touches scl and only drives sda while answering
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= S_IDLE;
      cnt_q     <= 4'h0;
      byteIdx_q <= 2'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      rnw_q     <= 1'h0;
      sdaOe_q   <= 1'h0;
    end else if (startSeen) begin
      state_q   <= S_RX;
      cnt_q     <= 4'h0;
      byteIdx_q <= 2'h0;
      sdaOe_q   <= 1'h0;
    end else if (stopSeen) begin
      state_q <= S_IDLE;
      sdaOe_q <= 1'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sdaOe_q <= 1'h0;
        end
        S_RX: begin
          if (sclRise && !rxFull) begin
            shift_q <= {shift_q[6:0], sdaNow};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byteDone) begin
            if (byteIdx_q == 2'h0) begin
              rnw_q <= (shift_q[0] == `HDI_READ_BIT);
            end
            if (byteIdx_q == 2'h1) begin
              ptr_q <= shift_q;
            end
            if (byteIdx_q == 2'h0 && addrMiss) begin
              state_q <= S_IDLE;
            end else begin
              sdaOe_q <= 1'h1;
              state_q <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (sclFall) begin
            if (byteIdx_q == 2'h0 && rnw_q) begin
              state_q <= S_TX;
              shift_q <= rdByte;
              sdaOe_q <= ~rdByte[7];
              cnt_q   <= 4'h0;
            end else if (byteIdx_q == 2'h2) begin
              state_q <= S_IDLE;
              sdaOe_q <= 1'h0;
            end else begin
              state_q   <= S_RX;
              sdaOe_q   <= 1'h0;
              cnt_q     <= 4'h0;
              byteIdx_q <= byteIdx_q + 2'h1;
            end
          end
        end
        S_TX: begin
          if (sclFall) begin
            if (cnt_q == 4'h7) begin
              sdaOe_q <= 1'h0;
              state_q <= S_RACK;
            end else begin
              cnt_q   <= cnt_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'h0};
              sdaOe_q <= ~shift_q[6];
            end
          end
        end
        S_RACK: begin
          // a single byte is returned whatever the master answers
          if (sclRise) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
          sdaOe_q <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    wire logic hit = wrEn & (ptr_q == 8'(i));
    hdi_byte_t nxt;

    always_comb begin
      nxt = hit ? (shift_q & regMask(i)) : regs_q[i];
      if (i == 0) begin
        // flag is sticky until reset; a write cannot clear or set it
        nxt[`HDI_TEMP_BIT] = regs_q[i][`HDI_TEMP_BIT] | overTemp;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        regs_q[i] <= regReset(i);
      end else begin
        regs_q[i] <= nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.sSdaOut = 1'h0;
  assign bus.sSdaOe  = sdaOe_q;
  assign cfgReg      = regs_q[0];
  assign oscReg      = regs_q[1];
  assign hapticAReg  = regs_q[2];
  assign hapticBReg  = regs_q[3];
  assign ldoHReg     = regs_q[4];
  assign ldoVReg     = regs_q[5];

endmodule

// ===== shared/hdi_defs.svh
`ifndef HDI_DEFS_SVH
`define HDI_DEFS_SVH

// bus address and direction
`define HDI_SLAVE_ADDR    7'h66
`define HDI_READ_BIT      1'h1
`define HDI_WRITE_BIT     1'h0

// register file
`define HDI_NUM_REGS      6
`define HDI_RST_CONFIG    8'h01
`define HDI_RST_OSC       8'h00
`define HDI_RST_HAPTIC_A  8'h0A
`define HDI_RST_HAPTIC_B  8'h85
`define HDI_RST_LDO_H     8'h00
`define HDI_RST_LDO_V     8'h1A
`define HDI_MSK_CONFIG    8'h1F
`define HDI_MSK_OSC       8'h0F
`define HDI_MSK_HAPTIC    8'hFF
`define HDI_MSK_LDO       8'h1F
`define HDI_TEMP_BIT      3

// timing
`define HDI_BIT_RATE_KBPS 400
`define HDI_CLK_PERIOD_NS 40
`define HDI_QTR_CYC       ((1000000 / `HDI_BIT_RATE_KBPS + 4 * `HDI_CLK_PERIOD_NS - 1) / (4 * `HDI_CLK_PERIOD_NS))
`define HDI_MIN_BIT_CYC   (1000000 / (`HDI_BIT_RATE_KBPS * `HDI_CLK_PERIOD_NS))
`endif

// ===== shared/hdi_if.sv
`timescale 1ns/1ps
interface hdi_if;
  logic mSclOut;
  logic mSclOe;
  logic mSdaOut;
  logic mSdaOe;
  logic sSdaOut;
  logic sSdaOe;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = ~(mSclOe & ~mSclOut);
  assign sda = ~((mSdaOe & ~mSdaOut) | (sSdaOe & ~sSdaOut));

  modport master (output mSclOut, output mSclOe, output mSdaOut, output mSdaOe, input scl, input sda);
  modport slave (output sSdaOut, output sSdaOe, input scl, input sda);
endinterface

// ===== shared/hdi_pkg.sv
package hdi_pkg;
  typedef logic [7:0] hdi_byte_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX   = 5'h02,
    S_ACK  = 5'h04,
    S_TX   = 5'h08,
    S_RACK = 5'h10
  } hdi_sst_t;

  typedef enum logic [6:0] {
    M_IDLE  = 7'h01,
    M_START = 7'h02,
    M_TXB   = 7'h04,
    M_ACKR  = 7'h08,
    M_RXB   = 7'h10,
    M_NACK  = 7'h20,
    M_STOP  = 7'h40
  } hdi_mst_t;
endpackage

// ===== sim/hdi_monitor.sv
`timescale 1ns/1ps
`include "hdi_defs.svh"
module hdi_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus
  input wire logic mSclOe,
  input wire logic mSdaOe,
  input wire logic sSdaOe,
  input wire logic scl,
  input wire logic sda
);
  ////////////////////////////////////////////////////////////////
  logic       sclQ;
  logic       sdaQ;
  logic       rdDir;
  logic [3:0] bitCnt;
  logic [3:0] sinceFall;
  logic [7:0] sinceRise;
  logic [1:0] byteNo;
  logic [7:0] shReg;
  wire rise = scl & ~sclQ;
  wire startEv = scl & sclQ & sdaQ & ~sda;
  wire stopEv = scl & sclQ & ~sdaQ & sda;
  // a repeated start restarts the byte count like a plain start
  always_ff @(posedge clk) begin
    sclQ <= scl;
    sdaQ <= sda;
    sinceFall <= (reset | (sclQ & ~scl)) ? 4'h0 : sinceFall + {3'h0, sinceFall != 4'hF};
    sinceRise <= (reset | rise) ? 8'h00 : sinceRise + {7'h00, sinceRise != 8'hFF};
    if (reset || startEv) begin
      bitCnt <= 4'h0;
      byteNo <= 2'h0;
      rdDir <= 1'b0;
    end else if (rise) begin
      bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
      byteNo <= byteNo + {1'b0, bitCnt == 4'h8};
      shReg <= (bitCnt < 4'h8) ? {shReg[6:0], sda} : shReg;
      rdDir <= (bitCnt == 4'h7 && byteNo == 2'h0) ? sda : rdDir;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence ackStart;
    $rose(sSdaOe);
  endsequence
  sequence ninthRise;
    rise && bitCnt == 4'h8;
  endsequence
  a_reset_release: assert property (disable iff (1'b0) reset |=> !mSclOe && !mSdaOe && !sSdaOe)
    else $error("bus not released in reset");
  a_stop_free: assert property (stopEv |-> !sSdaOe)
    else $error("slave holds sda at stop");
  a_slave_low_only: assert property ($changed(sSdaOe) |-> !scl && !sclQ)
    else $error("slave moved sda while scl high");
  a_ack_timing: assert property (ackStart |-> sinceFall >= 4'h1 && sinceFall <= 4'h7)
    else $error("slave drive not just after scl fall");
  a_ack_hold: assert property (ackStart |-> sSdaOe [*8])
    else $error("slave drive too short");
  a_ack_slots: assert property (rise && !rdDir && sSdaOe |-> bitCnt == 4'h8)
    else $error("slave pulled sda outside ack slot");
  a_write_acks: assert property (ninthRise ##0 (!rdDir && byteNo < 2'h3) |-> sSdaOe)
    else $error("write byte not acknowledged");
  a_addr_match: assert property (ninthRise ##0 byteNo == 2'h0 |-> sSdaOe == (shReg[7:1] == `HDI_SLAVE_ADDR))
    else $error("address ack does not follow match");
  a_read_data: assert property (rise && rdDir && byteNo == 2'h1 && bitCnt < 4'h8 |-> sda == !sSdaOe)
    else $error("read byte not driven by slave alone");
  a_read_nack: assert property (ninthRise ##0 (rdDir && byteNo == 2'h1) |-> !sSdaOe && sda)
    else $error("read byte not closed by nack");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
    else $error("scl high phase too short");
  // the count reads one below the period, which the rounded-down limit makes up for
  a_rate_ceiling: assert property (rise |-> sinceRise >= 8'(`HDI_MIN_BIT_CYC))
    else $error("scl bit period shorter than the rated ceiling allows");
endmodule

// ===== sim/test_haptic_driver_i2c_register_port.sv
`timescale 1ns/1ps
`include "hdi_defs.svh"
module test_haptic_driver_i2c_register_port import hdi_pkg::*;;
  // the bus runs at its rated ceiling; a shorter quarter would clock it too fast
  localparam int QTR = `HDI_QTR_CYC;
  logic        clk, reset, overTemp, reqValid, reqWrite, reqReady, rspValid, rspNack;
  hdi_byte_t   reqReg, reqData, rspData, cfgReg, oscReg, hapticAReg, hapticBReg, ldoHReg, ldoVReg;
  hdi_byte_t   regView [6];
  hdi_byte_t   rstVal [6];
  logic [24:0] rows [15];
  int          fail_count, checks_done, cyc, want;
  assign regView = '{cfgReg, oscReg, hapticAReg, hapticBReg, ldoHReg, ldoVReg};
  ////////////////////////////////////////////////////////////////
  hdi_if busIf();
  hdi_slave hdi_slave_inst (.clk(clk), .reset(reset), .bus(busIf), .overTemp(overTemp), .cfgReg(cfgReg),
    .oscReg(oscReg), .hapticAReg(hapticAReg), .hapticBReg(hapticBReg), .ldoHReg(ldoHReg), .ldoVReg(ldoVReg));
  hdi_master #(.QTR_CYC(QTR)) hdi_master_inst (.clk(clk), .reset(reset), .bus(busIf), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqReg(reqReg), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspNack(rspNack));
  hdi_monitor hdi_monitor_inst (.clk(clk), .reset(reset), .mSclOe(busIf.mSclOe), .mSdaOe(busIf.mSdaOe),
    .sSdaOe(busIf.sSdaOe), .scl(busIf.scl), .sda(busIf.sda));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmpByte(input string what, input hdi_byte_t exp, input hdi_byte_t got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %02X, seen %02X", what, exp, got);
    end
  endtask
  task automatic cmpBit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // entered just after a clock edge with the master idle
  task automatic doReq(input logic wr, input hdi_byte_t rg, input hdi_byte_t dt);
    reqWrite = wr;
    reqReg = rg;
    reqData = dt;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    cyc = 0;
    while (rspValid !== 1'b1 && cyc < 3000) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    want = (wr ? 29 : 39) * 4 * QTR;
  endtask
  task automatic checkReset;
    for (int k = 0; k < 6; k++) cmpByte("reset value", rstVal[k], regView[k]);
    cmpBit("idle scl", 1'b1, busIf.scl);
    cmpBit("idle sda", 1'b1, busIf.sda);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    overTemp = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqReg = 8'h00;
    reqData = 8'h00;
    fail_count = 0;
    checks_done = 0;
    rstVal = '{`HDI_RST_CONFIG, `HDI_RST_OSC, `HDI_RST_HAPTIC_A, `HDI_RST_HAPTIC_B, `HDI_RST_LDO_H, `HDI_RST_LDO_V};
    // write, register, data, expected register or read value
    rows = '{{1'h1, 8'h00, 8'hFF, 8'h17}, {1'h1, 8'h01, 8'hFF, 8'h0F}, {1'h1, 8'h02, 8'h5A, 8'h5A},
      {1'h1, 8'h03, 8'hC3, 8'hC3}, {1'h1, 8'h04, 8'hFF, 8'h1F}, {1'h1, 8'h05, 8'h07, 8'h07},
      {1'h1, 8'h06, 8'h55, 8'h00}, {1'h0, 8'h00, 8'h00, 8'h17}, {1'h0, 8'h01, 8'h00, 8'h0F},
      {1'h0, 8'h02, 8'h00, 8'h5A}, {1'h0, 8'h03, 8'h00, 8'hC3}, {1'h0, 8'h04, 8'h00, 8'h1F},
      {1'h0, 8'h05, 8'h00, 8'h07}, {1'h0, 8'h06, 8'h00, 8'h00}, {1'h0, 8'hFF, 8'h00, 8'h00}};
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    checkReset();
    $display("reset test done");
    for (int i = 0; i < 15; i++) begin
      doReq(rows[i][24], rows[i][23:16], rows[i][15:8]);
      cmpBit("nack", 1'b0, rspNack);
      cmpBit("frame length", 1'b1, cyc >= want - 2 && cyc <= want + 4);
      if (rows[i][24] && rows[i][23:16] < 8'h06) cmpByte("register", rows[i][7:0], regView[rows[i][18:16]]);
      if (!rows[i][24]) cmpByte("read data", rows[i][7:0], rspData);
      $display("row %0d done", i);
    end
    overTemp = 1'b1;
    @(posedge clk);
    #1;
    overTemp = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmpByte("flag set", 8'h1F, cfgReg);
    doReq(1'b1, 8'h00, 8'h00);
    cmpByte("flag kept", 8'h08, cfgReg);
    doReq(1'b0, 8'h00, 8'h00);
    cmpByte("flag read", 8'h08, rspData);
    $display("flag test done");
    // reset lands in the address byte of a second write frame
    doReq(1'b1, 8'h02, 8'hAA);
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    repeat (300) @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    checkReset();
    cmpBit("ready after reset", 1'b1, reqReady);
    doReq(1'b0, 8'h03, 8'h00);
    cmpByte("read after abort", `HDI_RST_HAPTIC_B, rspData);
    $display("abort test done");
    report_and_stop();
  end
  initial begin
    // about 660 bit slots are expected; 1000 leaves room without hiding a hang
    repeat (1000 * 4 * QTR) @(posedge clk);
    fail_count++;
    $display("unexpected run length: expected end of tests, seen watchdog");
    report_and_stop();
  end
endmodule
